//--- core/clk_low_timer.sv
// Serial clock held-low timeout detector
`timescale 1ns/10ps
module clk_low_timer import mon_cfg_pkg::*; #(
    parameter int TIMEOUT_CYC = TIMEOUT_CYCLES
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Control and line
    input wire logic disable_det,
    input wire logic scl_in,
    // Result
    output logic timeout_pulse
);
    localparam int CW = $clog2(TIMEOUT_CYC + 1);
    localparam logic [CW-1:0] LAST = CW'(TIMEOUT_CYC - 1);

    logic [CW-1:0] cnt_r, cnt_nxt;
    logic fired_r, fired_nxt;
    logic pulse_r, pulse_nxt;

    // ==========================================================
    // Counting
    // One pulse per low phase, so a stuck line does not flood the bus logic
    always_comb begin
        cnt_nxt = cnt_r;
        fired_nxt = fired_r;
        pulse_nxt = 1'b0;
        if (scl_in || disable_det) begin
            cnt_nxt = '0;
            fired_nxt = 1'b0;
        end else if (!fired_r) begin
            if (cnt_r == LAST) begin
                fired_nxt = 1'b1;
                pulse_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r <= '0;
            fired_r <= 1'b0;
            pulse_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            fired_r <= fired_nxt;
            pulse_r <= pulse_nxt;
        end
    end

    assign timeout_pulse = pulse_r;
endmodule : clk_low_timer

//--- core/mon_cfg_pkg.sv
// Package of register offsets, field positions and timing for the monitor configuration block
package mon_cfg_pkg;
    // ==========================================================
    // Register map
    localparam logic [7:0] ADDR_REVISION = 8'h3F;
    localparam logic [7:0] ADDR_CFG_ONE = 8'h40;
    localparam logic [7:0] ADDR_LATCH_FLAGS = 8'h42;
    localparam logic [7:0] ADDR_THERM_OPTS = 8'h7C;
    localparam logic [7:0] ADDR_CFG_FOUR = 8'h7D;
    localparam logic [7:0] ADDR_TEMP_OFFSET = 8'h70;
    localparam logic [7:0] ADDR_PWM_HF = 8'h71;
    localparam logic [7:0] ADDR_THERM_EN = 8'h72;
    // Revision value is arbitrary
    localparam logic [7:0] REVISION_VALUE = 8'h5A;
    // ==========================================================
    // Field positions
    localparam int CFG1_MON_EN = 0;
    localparam int CFG1_LOCK = 1;
    localparam int CFG1_LATCH_RESET = 7;
    localparam int FLAGS_LATCHED = 0;
    localparam int OPTS_HYST = 4;
    localparam int OPTS_OFS_WIDE = 5;
    localparam int CFG4_PIN_LO = 0;
    localparam int CFG4_PIN_HI = 1;
    localparam int CFG4_LATCH_BOTH = 4;
    localparam int CFG4_TMO_DIS = 5;
    // Writable masks; other bits are reserved
    localparam logic [7:0] CFG1_MASK = 8'h03;
    localparam logic [7:0] CFG1_MASK_LATCH = 8'h83;
    localparam logic [7:0] OPTS_MASK = 8'h20;
    localparam logic [7:0] OPTS_MASK_LATCH = 8'h30;
    localparam logic [7:0] CFG4_MASK = 8'h23;
    localparam logic [7:0] CFG4_MASK_LATCH = 8'h33;
    // ==========================================================
    // Reset values
    localparam logic [7:0] CFG1_RESET = 8'h01;
    localparam logic [7:0] OPTS_RESET = 8'h00;
    localparam logic [7:0] CFG4_RESET = 8'h00;
    localparam logic [7:0] OFFSET_RESET = 8'h00;
    localparam logic [7:0] THERM_EN_RESET = 8'h07;
    localparam logic [7:0] PWM_HF_RESET = 8'h00;
    // ==========================================================
    // Timing
    localparam int CLK_HZ = 20_000_000;
    localparam int TIMEOUT_MIN_MS = 15;
    localparam int TIMEOUT_MAX_MS = 35;
    localparam int TIMEOUT_CYCLES = (CLK_HZ / 1000) * TIMEOUT_MIN_MS;
    // ==========================================================
    // Multifunction pin roles
    typedef enum logic [1:0] {
        PIN_TACH = 2'b00,
        PIN_THERM = 2'b10,
        PIN_GPIO = 2'b01,
        PIN_ALERT = 2'b11
    } pin_role_t;
endpackage : mon_cfg_pkg

//--- core/monitor_config_and_pin_select.sv
// Configuration registers and multifunction pin selector of the thermal monitor
//
// Function
// - two config bits choose pin role
// - monitoring enable writable even when locked
// - configuration one bit 7 resets the overtemperature latch on the latch variant, no effect otherwise
// - per-channel high-frequency PWM select
// - offset scale half-degree or one-degree selectable
// - per-channel overtemperature alarm enable
// - detect clock low timeout, disableable
// - latch trigger source selectable on variant
// - configuration only through serial bus
// - alert pin active when limits exceeded
`timescale 1ns/10ps
module monitor_config_and_pin_select import mon_cfg_pkg::*; #(
    parameter bit LATCH_VARIANT = 1'b0,
    parameter int NUM_PWM = 3,
    parameter int NUM_TEMP = 3,
    parameter int TIMEOUT_CYC = TIMEOUT_CYCLES
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Register port from the serial bus slave
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // Serial clock line, for the timeout
    input wire logic scl_in,
    output logic bus_timeout,
    // Events from the monitoring loops
    input wire logic [NUM_TEMP-1:0] overtemp,
    input wire logic limit_exceeded,
    input wire logic gpio_out,
    input wire logic fan_tach_raw,
    // Multifunction pin, open drain
    input wire logic mf_pin_in,
    output logic mf_pin_out,
    output logic mf_pin_oe,
    output logic fourth_fan_speed_input,
    output logic gpio_in,
    // Configuration outputs
    output logic monitor_enable,
    output logic [NUM_PWM-1:0] pwm_high_freq,
    output logic offset_wide,
    output logic [7:0] temp_offset,
    output logic therm_hyst,
    // Overtemperature latch, latch-capable variant
    output logic therm_latch_out
);
    // ==========================================================
    // Helpers
    function automatic logic [7:0] masked(input logic [7:0] old, input logic [7:0] nw,
                                         input logic [7:0] m);
        masked = (old & ~m) | (nw & m);
    endfunction : masked

    localparam logic [7:0] M1 = LATCH_VARIANT ? CFG1_MASK_LATCH : CFG1_MASK;
    localparam logic [7:0] MO = LATCH_VARIANT ? OPTS_MASK_LATCH : OPTS_MASK;
    localparam logic [7:0] M4 = LATCH_VARIANT ? CFG4_MASK_LATCH : CFG4_MASK;
    localparam logic [7:0] MON_MASK = 8'h01;
    // Channel bits above the channel count are reserved
    localparam logic [7:0] HF_MASK = 8'((1 << NUM_PWM) - 1);
    localparam logic [7:0] TEN_MASK = 8'((1 << NUM_TEMP) - 1);

    logic [7:0] cfg1_r, cfg1_nxt;
    logic [7:0] opts_r, opts_nxt;
    logic [7:0] cfg4_r, cfg4_nxt;
    logic [7:0] ofs_r, ofs_nxt;
    logic [7:0] hf_r, hf_nxt;
    logic [7:0] ten_r, ten_nxt;
    logic latched_r, latched_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic rvalid_r;
    logic pin_out_r, pin_out_nxt;
    logic tach_r, tach_nxt, gin_r, gin_nxt, to_r;
    logic timeout_pulse;
    logic locked;
    logic therm_any;
    logic latch_trig;
    pin_role_t role;

    assign locked = cfg1_r[CFG1_LOCK];
    // Bit 1 is the upper bit of the role code, bit 0 the lower
    assign role = pin_role_t'({cfg4_r[CFG4_PIN_HI], cfg4_r[CFG4_PIN_LO]});
    // A disabled channel can never pull the alarm pin
    assign therm_any = |(overtemp & ten_r[NUM_TEMP-1:0]);
    // Channel 0 is local; 1 and 2 are the remote channels
    assign latch_trig = cfg4_r[CFG4_LATCH_BOTH] ? (overtemp[1] | overtemp[2])
                                                : overtemp[2];

    // ==========================================================
    // Register writes, the only configuration path
    // Lock freezes everything except the monitoring enable bit
    always_comb begin
        cfg1_nxt = cfg1_r;
        opts_nxt = opts_r;
        cfg4_nxt = cfg4_r;
        ofs_nxt = ofs_r;
        hf_nxt = hf_r;
        ten_nxt = ten_r;
        latched_nxt = latched_r;
        if (reg_wr) begin
            unique case (reg_addr)
                ADDR_CFG_ONE: begin
                    cfg1_nxt = locked ? masked(cfg1_r, reg_wdata, MON_MASK)
                                      : masked(cfg1_r, reg_wdata, M1);
                end
                ADDR_THERM_OPTS: if (!locked) opts_nxt = masked(opts_r, reg_wdata, MO);
                ADDR_CFG_FOUR: if (!locked) cfg4_nxt = masked(cfg4_r, reg_wdata, M4);
                ADDR_TEMP_OFFSET: if (!locked) ofs_nxt = reg_wdata;
                ADDR_PWM_HF: begin
                    if (!locked) hf_nxt = masked(hf_r, reg_wdata, HF_MASK);
                end
                ADDR_THERM_EN: begin
                    if (!locked) ten_nxt = masked(ten_r, reg_wdata, TEN_MASK);
                end
                default: ;
            endcase
        end
        // Latch reset bit is self-clearing; a trigger in the same cycle wins
        if (LATCH_VARIANT) begin
            if (cfg1_nxt[CFG1_LATCH_RESET]) begin
                latched_nxt = 1'b0;
                cfg1_nxt[CFG1_LATCH_RESET] = 1'b0;
            end
            if (latch_trig) latched_nxt = 1'b1;
        end
    end

    // ==========================================================
    // Register reads and pin drive
    always_comb begin
        rdata_nxt = rdata_r;
        pin_out_nxt = 1'b1;
        tach_nxt = (role == PIN_TACH) ? mf_pin_in : fan_tach_raw;
        gin_nxt = (role == PIN_GPIO) ? mf_pin_in : 1'b0;
        // Read data holds until the next read strobe
        if (reg_rd) begin
            unique case (reg_addr)
                ADDR_REVISION: rdata_nxt = REVISION_VALUE;
                ADDR_CFG_ONE: rdata_nxt = cfg1_r;
                ADDR_LATCH_FLAGS: rdata_nxt = {7'h00, LATCH_VARIANT & latched_r};
                ADDR_THERM_OPTS: rdata_nxt = opts_r;
                ADDR_CFG_FOUR: rdata_nxt = cfg4_r;
                ADDR_TEMP_OFFSET: rdata_nxt = ofs_r;
                ADDR_PWM_HF: rdata_nxt = hf_r;
                ADDR_THERM_EN: rdata_nxt = ten_r;
                default: rdata_nxt = 8'h00;
            endcase
        end
        // Open drain: a 0 here pulls the pin low
        unique case (role)
            PIN_THERM: pin_out_nxt = ~therm_any;
            PIN_GPIO: pin_out_nxt = gpio_out;
            PIN_ALERT: pin_out_nxt = ~limit_exceeded;
            PIN_TACH: pin_out_nxt = 1'b1;
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cfg1_r <= CFG1_RESET;
            opts_r <= OPTS_RESET;
            cfg4_r <= CFG4_RESET;
            ofs_r <= OFFSET_RESET;
            hf_r <= PWM_HF_RESET;
            ten_r <= THERM_EN_RESET;
            latched_r <= 1'b0;
            rdata_r <= 8'h00;
            rvalid_r <= 1'b0;
            pin_out_r <= 1'b1;
            tach_r <= 1'b0;
            gin_r <= 1'b0;
            to_r <= 1'b0;
        end else begin
            cfg1_r <= cfg1_nxt;
            opts_r <= opts_nxt;
            cfg4_r <= cfg4_nxt;
            ofs_r <= ofs_nxt;
            hf_r <= hf_nxt;
            ten_r <= ten_nxt;
            latched_r <= latched_nxt;
            rdata_r <= rdata_nxt;
            rvalid_r <= reg_rd;
            pin_out_r <= pin_out_nxt;
            tach_r <= tach_nxt;
            gin_r <= gin_nxt;
            to_r <= timeout_pulse;
        end
    end

    // ==========================================================
    // Clock low timeout
    // Detector runs even while locked; only its disable bit is frozen
    clk_low_timer #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_timer (
        .core_clk(core_clk),
        .nrst(nrst),
        .disable_det(cfg4_r[CFG4_TMO_DIS]),
        .scl_in(scl_in),
        .timeout_pulse(timeout_pulse)
    );

    // ==========================================================
    // Outputs
    assign reg_rdata = rdata_r;
    assign reg_rvalid = rvalid_r;
    assign bus_timeout = to_r;
    // Data stays low; only the enable moves, so the pin never drives high
    assign mf_pin_out = 1'b0;
    assign mf_pin_oe = pin_out_r;
    assign fourth_fan_speed_input = tach_r;
    assign gpio_in = gin_r;
    assign monitor_enable = cfg1_r[CFG1_MON_EN];
    assign pwm_high_freq = hf_r[NUM_PWM-1:0];
    assign offset_wide = opts_r[OPTS_OFS_WIDE];
    assign temp_offset = ofs_r;
    assign therm_hyst = opts_r[OPTS_HYST];
    assign therm_latch_out = latched_r;
endmodule : monitor_config_and_pin_select

//--- tb/mon_cfg_props.sv
// Assertion checker of the monitor configuration block
`timescale 1ns/10ps
module mon_cfg_props import mon_cfg_pkg::*; #(
    parameter int TIMEOUT_CYC = 20
) (
    // Clock, reset and register port
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rvalid,
    // Events and outputs
    input wire logic scl_in,
    input wire logic bus_timeout,
    input wire logic [2:0] overtemp,
    input wire logic limit_exceeded,
    input wire logic gpio_out,
    input wire logic mf_pin_oe,
    input wire logic monitor_enable,
    input wire logic [2:0] pwm_high_freq
);
    // ==========================================================
    // Shadow state, lock freezes the shadow like the real register
    logic lock_h;
    logic [7:0] cfg4_h;
    logic [2:0] ten_h;
    int unsigned low_cnt;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            lock_h <= 1'b0;
            cfg4_h <= CFG4_RESET;
            ten_h <= THERM_EN_RESET[2:0];
            low_cnt <= 0;
        end else begin
            if (reg_wr && reg_addr == ADDR_CFG_ONE && reg_wdata[CFG1_LOCK]) lock_h <= 1'b1;
            if (reg_wr && reg_addr == ADDR_CFG_FOUR && !lock_h) cfg4_h <= reg_wdata & CFG4_MASK;
            if (reg_wr && reg_addr == ADDR_THERM_EN && !lock_h) ten_h <= reg_wdata[2:0];
            low_cnt <= scl_in ? 0 : low_cnt + 1;
        end
    end
    // ==========================================================
    // Properties
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    property p_rvalid; reg_rd |=> reg_rvalid; endproperty
    a_rvalid: assert property (p_rvalid) else $error("read without answer");
    property p_no_rvalid; !reg_rd |=> !reg_rvalid; endproperty
    a_no_rvalid: assert property (p_no_rvalid) else $error("stray answer");
    property p_tach; cfg4_h[1:0] == 2'b00 |=> mf_pin_oe; endproperty
    a_tach: assert property (p_tach) else $error("pin driven in tach role");
    property p_gpio; cfg4_h[1:0] == 2'b01 |=> mf_pin_oe == $past(gpio_out); endproperty
    a_gpio: assert property (p_gpio) else $error("gpio pin wrong");
    property p_therm; cfg4_h[1:0] == 2'b10 |=> mf_pin_oe == !$past(|(overtemp & ten_h)); endproperty
    a_therm: assert property (p_therm) else $error("alarm pin wrong");
    property p_alert; cfg4_h[1:0] == 2'b11 |=> mf_pin_oe == !$past(limit_exceeded); endproperty
    a_alert: assert property (p_alert) else $error("alert pin wrong");
    property p_mon_en; reg_wr && reg_addr == ADDR_CFG_ONE |=> monitor_enable == $past(reg_wdata[0]);
    endproperty
    a_mon_en: assert property (p_mon_en) else $error("monitor enable not written");
    property p_pwm; reg_wr && reg_addr == ADDR_PWM_HF && !lock_h
        |=> pwm_high_freq == $past(reg_wdata[2:0]); endproperty
    a_pwm: assert property (p_pwm) else $error("pwm select wrong");
    property p_tmo; bus_timeout |-> low_cnt >= TIMEOUT_CYC && !cfg4_h[CFG4_TMO_DIS]; endproperty
    a_tmo: assert property (p_tmo) else $error("early or disabled timeout");
    c_tmo: cover property (bus_timeout);
    c_alert: cover property (cfg4_h[1:0] == 2'b11 && limit_exceeded);
    c_lock: cover property (lock_h && reg_wr);
endmodule : mon_cfg_props

bind monitor_config_and_pin_select mon_cfg_props #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_props (
    .core_clk(core_clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rvalid(reg_rvalid),
    .scl_in(scl_in), .bus_timeout(bus_timeout), .overtemp(overtemp),
    .limit_exceeded(limit_exceeded), .gpio_out(gpio_out), .mf_pin_oe(mf_pin_oe),
    .monitor_enable(monitor_enable), .pwm_high_freq(pwm_high_freq));

//--- tb/reg_master_model.sv
// Register master model standing on the far side of the block
`timescale 1ns/10ps
module reg_master_model (
    // Clock
    input wire logic core_clk,
    // Requests
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata
);
    // Idle bus shows inverted values, never a stale match
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'hFF;
        reg_wdata = 8'hFF;
    end
    // Every setting goes through these requests only
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge core_clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(negedge core_clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge core_clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
    endtask : rd
endmodule : reg_master_model

//--- tb/test_monitor_config_and_pin_select.sv
// Self-checking bench of the monitor configuration block
`timescale 1ns/10ps
module test_monitor_config_and_pin_select import mon_cfg_pkg::*;;
    logic core_clk = 1'b0, nrst = 1'b0, scl_in = 1'b1, limit_exceeded = 1'b0;
    logic gpio_out = 1'b0, fan_tach_raw = 1'b0, ext_lvl = 1'b1;
    logic [2:0] overtemp = 3'h0, pwm_high_freq;
    logic reg_wr, reg_rd, reg_rvalid, bus_timeout, mf_pin_out, mf_pin_oe, gpio_in;
    logic fourth_fan_speed_input, monitor_enable, offset_wide, therm_hyst, therm_latch_out;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, temp_offset, r;
    logic [7:0] exp_q[$];
    int err_count = 0, checks_done = 0, tmo_seen = 0;
    integer seed = 32'h478c;
    // Open-drain pin: low while driven, else the outside level
    wire mf_pin = mf_pin_oe ? ext_lvl : mf_pin_out;
    initial forever #25 core_clk = ~core_clk;
    reg_master_model m (.core_clk(core_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata));
    monitor_config_and_pin_select #(.TIMEOUT_CYC(20)) dut (.core_clk(core_clk), .nrst(nrst),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .scl_in(scl_in),
        .bus_timeout(bus_timeout), .overtemp(overtemp), .limit_exceeded(limit_exceeded),
        .gpio_out(gpio_out), .fan_tach_raw(fan_tach_raw), .mf_pin_in(mf_pin),
        .mf_pin_out(mf_pin_out), .mf_pin_oe(mf_pin_oe),
        .fourth_fan_speed_input(fourth_fan_speed_input), .gpio_in(gpio_in),
        .monitor_enable(monitor_enable), .pwm_high_freq(pwm_high_freq),
        .offset_wide(offset_wide), .temp_offset(temp_offset), .therm_hyst(therm_hyst),
        .therm_latch_out(therm_latch_out));
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        m.rd(a);
    endtask : rd
    task step;
        @(negedge core_clk);
    endtask : step
    task end_sim;
        $display("checks=%0d mismatches=%0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_sim
    // Answers are compared in order of request
    always @(posedge core_clk) begin
        if (reg_rvalid === 1'b1) chk(reg_rdata, exp_q.pop_front());
        if (bus_timeout === 1'b1) tmo_seen++;
    end
    initial begin
        logic [7:0] ad[8] = '{ADDR_REVISION, ADDR_CFG_ONE, ADDR_THERM_OPTS, ADDR_CFG_FOUR,
            ADDR_TEMP_OFFSET, ADDR_PWM_HF, ADDR_THERM_EN, 8'h10};
        logic [7:0] ex[8] = '{REVISION_VALUE, CFG1_RESET, OPTS_RESET, CFG4_RESET,
            OFFSET_RESET, PWM_HF_RESET, THERM_EN_RESET, 8'h00};
        repeat (8) step;
        nrst = 1'b1;
        for (int i = 0; i < 8; i++) rd(ad[i], ex[i]);
        $display("reset values done");
        m.wr(ADDR_CFG_FOUR, 8'hFF);
        rd(ADDR_CFG_FOUR, CFG4_MASK);
        m.wr(ADDR_CFG_ONE, 8'h80);
        rd(ADDR_CFG_ONE, 8'h00);
        m.wr(ADDR_CFG_ONE, 8'h01);
        $display("reserved bits done");
        m.wr(ADDR_CFG_FOUR, {6'h0, PIN_TACH});
        ext_lvl = 1'b0;
        fan_tach_raw = 1'b1;
        repeat (2) step;
        chk({mf_pin_out, mf_pin_oe, fourth_fan_speed_input}, 8'h02);
        m.wr(ADDR_CFG_FOUR, {6'h0, PIN_GPIO});
        step;
        chk(mf_pin_oe, 8'h00);
        gpio_out = 1'b1;
        ext_lvl = 1'b1;
        repeat (2) step;
        chk({fourth_fan_speed_input, mf_pin_oe, gpio_in}, 8'h07);
        m.wr(ADDR_CFG_FOUR, {6'h0, PIN_THERM});
        overtemp = 3'h2;
        step;
        chk(mf_pin_oe, 8'h00);
        m.wr(ADDR_THERM_EN, 8'h05);
        step;
        chk(mf_pin_oe, 8'h01);
        overtemp = 3'h0;
        m.wr(ADDR_CFG_FOUR, {6'h0, PIN_ALERT});
        limit_exceeded = 1'b1;
        step;
        chk(mf_pin_oe, 8'h00);
        limit_exceeded = 1'b0;
        step;
        chk(mf_pin_oe, 8'h01);
        $display("pin roles done");
        repeat (4) begin
            r = 8'($random(seed));
            m.wr(ADDR_TEMP_OFFSET, r);
            rd(ADDR_TEMP_OFFSET, r);
            chk(temp_offset, r);
            m.wr(ADDR_PWM_HF, r);
            chk(pwm_high_freq, r[2:0]);
            m.wr(ADDR_THERM_OPTS, r);
            chk(offset_wide, r[OPTS_OFS_WIDE]);
            chk({therm_latch_out, therm_hyst}, 8'h00);
        end
        $display("random settings done");
        for (int k = 0; k < 2; k++) begin
            m.wr(ADDR_CFG_FOUR, k ? 8'h20 : 8'h00);
            scl_in = 1'b0;
            repeat (30) step;
            scl_in = 1'b1;
            step;
            chk(tmo_seen[7:0], 8'h01);
        end
        $display("timeout done");
        m.wr(ADDR_CFG_ONE, 8'h03);
        m.wr(ADDR_CFG_FOUR, 8'h03);
        rd(ADDR_CFG_FOUR, 8'h20);
        m.wr(ADDR_CFG_ONE, 8'h00);
        chk(monitor_enable, 8'h00);
        rd(ADDR_CFG_ONE, 8'h02);
        repeat (2) step;
        $display("lock done");
        end_sim;
    end
    // Whole run needs under two hundred cycles
    initial begin
        #(50 * 20000);
        err_count++;
        end_sim;
    end
endmodule : test_monitor_config_and_pin_select
